// ===== core/trap_and_interrupt_controller.sv
// Trap prioritiser, interrupt arbiter, context stacking and shadow store for the core
`timescale 1ns/100ps
`default_nettype none
module trap_and_interrupt_controller
    import trap_irq_pkg::*;
#(
    parameter int unsigned NUM_SRC      = 16,
    parameter int unsigned STACK_DEPTH  = 8,
    parameter logic [23:0] PROG_TOP     = 24'h018000,
    parameter logic [23:0] DEFAULT_BASE = 24'h000004,
    parameter logic [23:0] ALT_BASE     = 24'h000084
)
(
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                clkEn,
    input  wire logic [3:0]          regAddr,
    input  wire logic [15:0]         regWdata,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output var  logic [15:0]         regRdata,
    input  wire logic                instrStart,
    input  wire logic [23:0]         currentPc,
    input  wire logic [4:0]          statusFlags,
    input  wire logic                branchValid,
    input  wire logic [23:0]         branchTarget,
    input  wire logic                fetchValid,
    input  wire logic [23:0]         fetchAddr,
    input  wire logic                spLoad,
    input  wire logic [15:0]         spValue,
    input  wire logic                mathErr,
    input  wire logic                oscFailPin,
    input  wire logic [NUM_EXT-1:0]  externalIrqInputs,
    input  wire logic [NUM_SRC-1:0]  periphEvents,
    input  wire logic                trapAck,
    input  wire logic                return_from_interrupt_instr,
    input  wire logic [7:0]          poppedSrl,
    input  wire logic                shadowPush,
    input  wire logic                shadowPop,
    input  wire shadow_t             liveCtx,
    input  wire logic                sleeping,
    output var  logic                takeStrobe,
    output var  frame_t              pushFrame,
    output var  logic [23:0]         vectorAddr,
    output var  logic                haltExec,
    output var  logic                conflictReset,
    output var  logic                wakeCore,
    output var  logic [2:0]          cpuPriorityLevel,
    output var  logic                trapPriorityBit,
    output var  shadow_t             shadowCtx,
    output var  logic                shadowPopValid
);

    function automatic logic isUnimpl(input logic [23:0] addr);
        isUnimpl = (addr >= PROG_TOP);
    endfunction : isUnimpl

    // Highest level among a set of pending trap bits
    function automatic logic [3:0] trapLevelOf(input logic [3:0] pend);
        if (pend[TRAP_OSC])
            trapLevelOf = LVL_OSC;
        else if (pend[TRAP_STACK])
            trapLevelOf = LVL_STACK;
        else if (pend[TRAP_ADDR])
            trapLevelOf = LVL_ADDR;
        else if (pend[TRAP_MATH])
            trapLevelOf = LVL_MATH;
        else
            trapLevelOf = 4'h0;
    endfunction : trapLevelOf

    ctl_state_t               state;
    ctl_state_t               next_state;
    take_t                    sel;
    take_t                    cand;
    logic [NUM_EXT-1:0]       extSync1;
    logic [NUM_EXT-1:0]       extSync2;
    logic [NUM_EXT-1:0]       extPrev;
    logic [NUM_EXT-1:0]       extPol;
    logic                     oscSync1;
    logic                     oscSync2;
    logic                     oscPrev;
    logic                     altVec;
    logic [NUM_SRC-1:0]       evLatch;
    logic [NUM_SRC-1:0]       flags;
    logic [NUM_SRC-1:0]       enables;
    logic [2:0]               prio [NUM_SRC];
    logic [15:0]              prioWord [PRIO_WORDS];
    logic [15:0]              stackLimit;
    logic [3:0]               trapPend;
    logic                     conflictFlag;
    logic [STACK_DEPTH-1:0]   trapStack;
    logic [3:0]               svcHardLvl;
    shadow_t                  shadowReg;
    logic [2:0]               bestLvl;
    logic [5:0]               bestIdx;
    logic [15:0]              rdMux;

    wire logic                softRst   = !rst_b || conflictReset;
    wire logic                wrTrap    = regWr && (regAddr == REG_TRAP_STAT);
    wire logic                wrCtrl2   = regWr && (regAddr == REG_INT_CTRL2);
    wire logic                wrFlags   = regWr && (regAddr == REG_FLAGS);
    wire logic                wrEnables = regWr && (regAddr == REG_ENABLES);
    wire logic                wrLimit   = regWr && (regAddr == REG_STACK_LIMIT);
    wire logic                wrResCtrl = regWr && (regAddr == REG_RESET_CTRL);
    wire logic                wrStatus  = regWr && (regAddr == REG_STATUS);

    // External edges: polarity 0 rising, 1 falling
    wire logic [NUM_EXT-1:0]  extEdge   = (~extPol & extSync2 & ~extPrev)
                                        | (extPol & ~extSync2 & extPrev);
    wire logic [NUM_SRC-1:0]  evNow     = periphEvents | NUM_SRC'(extEdge);
    // Events between instruction starts are held so a short pulse is not lost
    wire logic [NUM_SRC-1:0]  flagSet   = instrStart ? (evLatch | evNow) : '0;
    wire logic [NUM_SRC-1:0]  next_flags = (wrFlags ? regWdata[NUM_SRC-1:0] : flags)
                                         | flagSet;

    // Trap detection
    wire logic                addrErrNow  = (branchValid && isUnimpl(branchTarget))
                                          || (fetchValid && isUnimpl(fetchAddr));
    wire logic                stackOver   = spLoad && (spValue > stackLimit);
    wire logic                stackUnder  = spLoad && (spValue < STACK_FLOOR);
    wire logic                oscFailNow  = oscSync2 && !oscPrev;
    wire logic [3:0]          trapSet     = {oscFailNow, stackOver || stackUnder,
                                             addrErrNow, mathErr};
    wire logic [3:0]          next_trapPend = (wrTrap ? (trapPend & ~regWdata[3:0]) : trapPend)
                                            | trapSet;

    // Conflict: a new hard trap below a level already pending or in service
    wire logic [3:0]          newHard     = trapSet & ~trapPend & HARD_MASK;
    wire logic [3:0]          pendHardLvl = trapLevelOf(trapPend & HARD_MASK);
    wire logic [3:0]          busyLvl     = (pendHardLvl > svcHardLvl) ? pendHardLvl
                                                                       : svcHardLvl;
    wire logic                conflict    = (newHard[TRAP_ADDR] && busyLvl > LVL_ADDR)
                                          || (newHard[TRAP_STACK] && busyLvl > LVL_STACK)
                                          || (newHard[TRAP_OSC] && busyLvl > LVL_OSC);

    // Arbitration against the current level; trap bit lifts it into 8..15
    wire logic [3:0]          curLevel    = {trapPriorityBit, cpuPriorityLevel};
    wire logic [3:0]          trapLvl     = trapLevelOf(trapPend);
    wire logic                useTrap     = trapLvl > curLevel;
    wire logic                useIrq      = (bestLvl != 3'h0) && ({1'b0, bestLvl} > curLevel);
    wire logic                candValid   = useTrap || useIrq;
    wire logic [3:0]          candLevel   = useTrap ? trapLvl : {1'b0, bestLvl};
    wire logic [5:0]          candVec     = useTrap ? VEC_TRAP_BASE + 6'(trapLvl - LVL_SOFT_MIN)
                                                    : VEC_IRQ_BASE + bestIdx;
    wire logic                candHard    = useTrap && (trapLvl >= LVL_HARD_MIN);
    wire logic                selHard     = sel.isTrap && (sel.level >= LVL_HARD_MIN);
    wire logic                takeGo      = (state == ST_RUN) && candValid && !return_from_interrupt_instr;
    wire logic                retfieGo    = return_from_interrupt_instr && (state != ST_TAKE);
    wire logic [23:0]         tableBase   = altVec ? ALT_BASE : DEFAULT_BASE;
    wire logic [23:0]         next_vector = tableBase + 24'({candVec, 1'b0});

    assign cand = {useTrap, candLevel, candVec};

    // Highest enabled nonzero priority; lowest source wins a tie
    always_comb
    begin
        bestLvl = 3'h0;
        bestIdx = 6'h00;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (flags[i] && enables[i] && (prio[i] > bestLvl))
            begin
                bestLvl = prio[i];
                bestIdx = 6'(i);
            end
        end
    end

    always_comb
    begin
        for (int k = 0; k < PRIO_WORDS; k++)
            prioWord[k] = 16'h0000;
        for (int i = 0; i < NUM_SRC; i++)
            prioWord[i / PRIO_FIELD_STEP][(i % PRIO_FIELD_STEP) * PRIO_FIELD_STEP +: 3] = prio[i];
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:  if (takeGo) next_state = ST_TAKE;
            ST_TAKE: next_state = selHard ? ST_HALT : ST_RUN;
            ST_HALT: if (trapAck) next_state = ST_RUN;
            default: next_state = ST_RUN;
        endcase
    end

    always_comb
    begin
        case (regAddr)
            REG_TRAP_STAT:   rdMux = 16'(trapPend);
            REG_INT_CTRL2:   rdMux = (16'(altVec) << ALT_VEC_BIT) | 16'(extPol);
            REG_FLAGS:       rdMux = 16'(flags);
            REG_ENABLES:     rdMux = 16'(enables);
            REG_PRIO0:       rdMux = prioWord[0];
            REG_PRIO0 + 4'h1: rdMux = prioWord[1];
            REG_PRIO0 + 4'h2: rdMux = prioWord[2];
            REG_PRIO0 + 4'h3: rdMux = prioWord[3];
            REG_STACK_LIMIT: rdMux = stackLimit;
            REG_RESET_CTRL:  rdMux = 16'(conflictFlag) << CONFLICT_BIT;
            REG_CORE_CTRL:   rdMux = 16'(trapPriorityBit) << TRAP_PRIO_BIT;
            REG_STATUS:      rdMux = (16'(cpuPriorityLevel) << STATUS_LVL_LSB) | 16'(statusFlags);
            REG_INT_STATE:   rdMux = (16'(sel.level) << INT_STATE_LVL_LSB) | 16'(sel.vecNum);
            default:         rdMux = 16'h0000;
        endcase
    end

    // Pins cross into this clock through two flops before any edge logic
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            extSync1 <= '0;
            extSync2 <= '0;
            extPrev  <= '0;
            oscSync1 <= 1'b0;
            oscSync2 <= 1'b0;
            oscPrev  <= 1'b0;
        end
        else if (clkEn)
        begin
            extSync1 <= externalIrqInputs;
            extSync2 <= extSync1;
            extPrev  <= extSync2;
            oscSync1 <= oscFailPin;
            oscSync2 <= oscSync1;
            oscPrev  <= oscSync2;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (softRst)
        begin
            evLatch    <= '0;
            flags      <= '0;
            enables    <= '0;
            extPol     <= '0;
            altVec     <= 1'b0;
            stackLimit <= STACK_LIMIT_RST;
            trapPend   <= 4'h0;
        end
        else if (clkEn)
        begin
            evLatch  <= instrStart ? '0 : (evLatch | evNow);
            flags    <= next_flags;
            trapPend <= next_trapPend;
            if (wrEnables)
                enables <= regWdata[NUM_SRC-1:0];
            if (wrCtrl2)
            begin
                altVec <= regWdata[ALT_VEC_BIT];
                extPol <= regWdata[NUM_EXT-1:0];
            end
            if (wrLimit)
                stackLimit <= regWdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (softRst)
                prio[i] <= PRIO_RST;
            else if (clkEn && regWr && regAddr == REG_PRIO0 + 4'(i / PRIO_FIELD_STEP))
                prio[i] <= regWdata[(i % PRIO_FIELD_STEP) * PRIO_FIELD_STEP +: 3];
        end
    end

    // Conflict flag survives the block reset it causes so software can see it
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            conflictReset <= 1'b0;
            conflictFlag  <= 1'b0;
            regRdata      <= 16'h0000;
        end
        else if (clkEn)
        begin
            conflictReset <= conflict;
            conflictFlag  <= (wrResCtrl ? regWdata[CONFLICT_BIT] : conflictFlag) | conflict;
            regRdata      <= regRd ? rdMux : 16'h0000;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (softRst)
        begin
            state      <= ST_RUN;
            sel        <= '0;
            takeStrobe <= 1'b0;
            pushFrame  <= '0;
            vectorAddr <= 24'h000000;
            haltExec   <= 1'b0;
            wakeCore   <= 1'b0;
        end
        else if (clkEn)
        begin
            state      <= next_state;
            takeStrobe <= takeGo;
            wakeCore   <= sleeping && candValid;
            if (takeGo)
            begin
                sel        <= cand;
                pushFrame  <= {currentPc, curLevel[2:0], statusFlags};
                vectorAddr <= next_vector;
            end
            if (takeGo && candHard)
                haltExec <= 1'b1;
            else if (state == ST_HALT && trapAck)
                haltExec <= 1'b0;
        end
    end

    // Level, trap bit and a small stack of trap/interrupt kinds for nesting
    always_ff @(posedge ref_clk)
    begin
        if (softRst)
        begin
            cpuPriorityLevel <= 3'h0;
            trapPriorityBit  <= 1'b0;
            trapStack        <= '0;
            svcHardLvl       <= 4'h0;
        end
        else if (clkEn)
        begin
            if (state == ST_TAKE)
            begin
                {trapPriorityBit, cpuPriorityLevel} <= sel.level;
                trapStack <= {trapStack[STACK_DEPTH-2:0], trapPriorityBit};
                if (selHard)
                    svcHardLvl <= sel.level;
            end
            else if (retfieGo)
            begin
                cpuPriorityLevel <= poppedSrl[STATUS_LVL_LSB +: 3];
                trapPriorityBit  <= trapStack[0];
                trapStack        <= {1'b0, trapStack[STACK_DEPTH-1:1]};
                if (trapPriorityBit)
                    svcHardLvl <= 4'h0;
            end
            else if (wrStatus)
                cpuPriorityLevel <= regWdata[STATUS_LVL_LSB +: 3];
        end
    end

    // Only the pin reset and the shadow push and pop strobes reach this store
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            shadowReg      <= '0;
            shadowPopValid <= 1'b0;
        end
        else if (clkEn)
        begin
            if (shadowPush)
                shadowReg <= liveCtx;
            shadowPopValid <= shadowPop;
        end
    end

    assign shadowCtx = shadowReg;

    a_addr_error: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && branchValid && (branchTarget >= PROG_TOP) |=> trapPend[TRAP_ADDR])
        else $error("Unimplemented branch target raised no address error");

    a_stack_over: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && spLoad && (spValue > stackLimit) |=> trapPend[TRAP_STACK])
        else $error("Stack overflow raised no stack error");

    a_stack_under: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && spLoad && (spValue < STACK_FLOOR) |=> trapPend[TRAP_STACK])
        else $error("Stack underflow raised no stack error");

    a_flag_sample: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && !conflictReset && instrStart && periphEvents[NUM_SRC-1] |=> flags[NUM_SRC-1])
        else $error("Event at instruction start not sampled into flags");

    a_no_low_take: assert property (
        @(posedge ref_clk) disable iff (softRst)
        takeStrobe |-> ($past(cand.level) > $past(curLevel)))
        else $error("Request taken without exceeding the CPU level");

    a_halt_holds: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && !conflictReset && haltExec && !trapAck |=> haltExec)
        else $error("Hard trap halt released without acknowledge");

    a_level_load: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && !conflictReset && (state == ST_TAKE)
        |=> ({trapPriorityBit, cpuPriorityLevel} == $past(sel.level)) && !takeStrobe)
        else $error("Accepted level not loaded after stacking");

    a_trap_bit_irq: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && (state == ST_TAKE) && !sel.isTrap |=> !trapPriorityBit)
        else $error("Trap priority bit set while servicing an interrupt");

    a_conflict_set: assert property (
        @(posedge ref_clk) disable iff (!rst_b)
        clkEn && conflict |=> conflictReset && conflictFlag ##1 (state == ST_RUN))
        else $error("Hard trap conflict did not reset and flag");

    a_alt_vector: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && takeGo && altVec |=> (vectorAddr == ALT_BASE + 24'({sel.vecNum, 1'b0})))
        else $error("Vector not fetched from the alternate table");

    a_wake_req: assert property (
        @(posedge ref_clk) disable iff (softRst)
        clkEn && sleeping && candValid && (state == ST_RUN) && !return_from_interrupt_instr
        |=> wakeCore && takeStrobe)
        else $error("Sleeping core not woken and interrupted");

endmodule : trap_and_interrupt_controller
`default_nettype wire

// ===== core/trap_irq_pkg.sv
// Shared constants and types of the trap and interrupt controller
`default_nettype none
package trap_irq_pkg;
    // Register indexes on the plain register port
    localparam logic [3:0]  REG_TRAP_STAT     = 4'h0;
    localparam logic [3:0]  REG_INT_CTRL2     = 4'h1;
    localparam logic [3:0]  REG_FLAGS         = 4'h2;
    localparam logic [3:0]  REG_ENABLES       = 4'h3;
    localparam logic [3:0]  REG_PRIO0         = 4'h4;
    localparam logic [3:0]  REG_STACK_LIMIT   = 4'h8;
    localparam logic [3:0]  REG_RESET_CTRL    = 4'h9;
    localparam logic [3:0]  REG_CORE_CTRL     = 4'ha;
    localparam logic [3:0]  REG_STATUS        = 4'hb;
    localparam logic [3:0]  REG_INT_STATE     = 4'hc;
    localparam int unsigned PRIO_WORDS        = 4;
    localparam int unsigned PRIO_FIELD_STEP   = 4;
    // Field positions
    localparam int unsigned ALT_VEC_BIT       = 15;
    localparam int unsigned CONFLICT_BIT      = 15;
    localparam int unsigned TRAP_PRIO_BIT     = 3;
    localparam int unsigned STATUS_LVL_LSB    = 5;
    localparam int unsigned INT_STATE_LVL_LSB = 8;
    // Trap pending bit positions
    localparam int unsigned TRAP_MATH         = 0;
    localparam int unsigned TRAP_ADDR         = 1;
    localparam int unsigned TRAP_STACK        = 2;
    localparam int unsigned TRAP_OSC          = 3;
    localparam logic [3:0]  HARD_MASK         = 4'he;
    // Exception levels
    localparam logic [3:0]  LVL_SOFT_MIN      = 4'h8;
    localparam logic [3:0]  LVL_MATH          = 4'hb;
    localparam logic [3:0]  LVL_HARD_MIN      = 4'hc;
    localparam logic [3:0]  LVL_ADDR          = 4'hc;
    localparam logic [3:0]  LVL_STACK         = 4'hd;
    localparam logic [3:0]  LVL_OSC           = 4'he;
    // Reset values, limits, vector number bases and external source count
    localparam logic [15:0] STACK_FLOOR       = 16'h0800;
    localparam logic [15:0] STACK_LIMIT_RST   = 16'hfffe;
    localparam logic [2:0]  PRIO_RST          = 3'h4;
    localparam logic [5:0]  VEC_TRAP_BASE     = 6'h00;
    localparam logic [5:0]  VEC_IRQ_BASE      = 6'h08;
    localparam int unsigned NUM_EXT           = 5;

    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_TAKE = 2'b01,
        ST_HALT = 2'b11
    } ctl_state_t;

    typedef struct packed {
        logic       isTrap;
        logic [3:0] level;
        logic [5:0] vecNum;
    } take_t;

    typedef struct packed {
        logic [23:0] pc;
        logic [7:0]  status_low_byte;
    } frame_t;

    typedef struct packed {
        logic [4:0]  flags;
        logic [15:0] wThree;
        logic [15:0] wTwo;
        logic [15:0] wOne;
        logic [15:0] wZero;
    } shadow_t;
endpackage : trap_irq_pkg
`default_nettype wire

// ===== bench/core_model.sv
// Core-side model: instruction cycles and slow hard trap acknowledge
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input  wire logic ref_clk,
    input  wire logic haltExec,
    output var  logic instrStart,
    output var  logic trapAck
);
    logic [1:0] phase = 2'h0;
    initial instrStart = 1'b0;
    initial trapAck = 1'b0;
    // Ack waits for a phase slot, so it is not always prompt
    always @(posedge ref_clk)
    begin
        phase      <= phase + 2'h1;
        instrStart <= (phase == 2'h3) && !haltExec;
        trapAck    <= haltExec && (phase == 2'h1);
    end
endmodule : core_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the trap and interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tb
    import trap_irq_pkg::*;
;
    localparam logic [23:0] DBASE = 24'h000004;
    localparam logic [23:0] ABASE = 24'h000084;
    logic        ref_clk, instrStart, trapAck, takeStrobe, haltExec, tpb;
    logic        rst_b = 1'b0, regWr = 1'b0, regRd = 1'b0, z = 1'b0;
    logic        spLoad = 1'b0, mathErr = 1'b0, return_from_interrupt_instr = 1'b0;
    logic        bv = 1'b0, osc = 1'b0, slp = 1'b0, shPush = 1'b0, shPop = 1'b0, cr, wk, spv;
    logic [3:0]  regAddr = 4'h0, el;
    logic [15:0] regWdata = 16'h0, spValue = 16'h0, pev = 16'h0, regRdata, v;
    logic [23:0] pc = 24'h0, vectorAddr;
    logic [4:0]  sf = 5'h0, ext = 5'h0;
    logic [2:0]  lvl;
    frame_t      pushFrame;
    shadow_t     live = '0, shc;
    int          failures = 0, check_count = 0, seed = 32'hc316;
    trap_and_interrupt_controller #(.DEFAULT_BASE(DBASE), .ALT_BASE(ABASE)) uut (
        .ref_clk, .rst_b, .clkEn(1'b1), .regAddr, .regWdata, .regWr, .regRd, .regRdata,
        .instrStart, .currentPc(pc), .statusFlags(sf), .branchValid(bv),
        .branchTarget(pc | 24'h800000), .fetchValid(z), .fetchAddr(pc), .spLoad, .spValue,
        .mathErr, .oscFailPin(osc), .externalIrqInputs(ext), .periphEvents(pev), .trapAck,
        .return_from_interrupt_instr, .poppedSrl(8'h0), .shadowPush(shPush), .shadowPop(shPop), .liveCtx(live),
        .sleeping(slp), .takeStrobe, .pushFrame, .vectorAddr, .haltExec, .conflictReset(cr),
        .wakeCore(wk), .cpuPriorityLevel(lvl), .trapPriorityBit(tpb), .shadowCtx(shc),
        .shadowPopValid(spv));
    core_model core (.ref_clk, .haltExec, .instrStart, .trapAck);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t saw %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        #1 d = regRdata;
    endtask : rd
    // Waits for a take, then checks vector, frame, halt and the level loaded after it
    task automatic take(input logic [23:0] vec, input logic hard, input logic [3:0] lv);
        int n;
        n = 0;
        while (takeStrobe !== 1'b1 && n < 60)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        check(32'(n < 60), 32'h1);
        check(vectorAddr, vec);
        check(pushFrame, {pc, 3'h0, sf});
        check(haltExec, hard);
        check(wk, slp);
        @(posedge ref_clk);
        #1 check({tpb, lvl}, lv);
        // Pending bits and flags are cleared first, or return_from_interrupt_instr would retake at once
        wr(REG_TRAP_STAT, 16'h000f);
        wr(REG_FLAGS, 16'h0000);
        @(posedge ref_clk);
        return_from_interrupt_instr <= 1'b1;
        @(posedge ref_clk);
        return_from_interrupt_instr <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({tpb, lvl}, 4'h0);
    endtask : take
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial
    begin
        #20000;
        failures++;
        final_report();
    end
    initial
    begin
        pc = 24'($random(seed));
        sf = 5'($random(seed));
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        rd(REG_STACK_LIMIT, v);
        check(v, STACK_LIMIT_RST);
        rd(REG_PRIO0, v);
        check(v, 16'h4444);
        wr(REG_ENABLES, 16'h0020);
        for (int alt = 1; alt >= 0; alt--)
        begin
            wr(REG_INT_CTRL2, alt != 0 ? 16'h8000 : 16'h0000);
            @(posedge ref_clk);
            pev <= 16'h0020;
            slp <= alt != 0;
            @(posedge ref_clk);
            pev <= 16'h0000;
            take((alt != 0 ? ABASE : DBASE) + 24'h00001a, 1'b0, 4'h4);
        end
        // Source 2 outranks source 1, so a wrong-polarity edge on it would win the take
        wr(REG_ENABLES, 16'h0006);
        wr(REG_PRIO0, 16'h0544);
        wr(REG_INT_CTRL2, 16'h0004);
        for (int e = 0; e < 2; e++)
        begin
            @(posedge ref_clk);
            ext <= e == 0 ? 5'h06 : 5'h00;
            take(DBASE + 24'h000012 + 24'(2 * e), 1'b0, 4'h4 + 4'(e));
        end
        wr(REG_STACK_LIMIT, 16'h1000);
        for (int k = 0; k < 5; k++)
        begin
            el = k < 2 ? LVL_STACK : k == 2 ? LVL_MATH : k == 3 ? LVL_ADDR : LVL_OSC;
            @(posedge ref_clk);
            spValue <= k == 0 ? (16'($random(seed)) & 16'h07fe) : 16'h1002;
            spLoad  <= k < 2;
            mathErr <= k == 2;
            bv      <= k == 3;
            osc     <= k == 4;
            @(posedge ref_clk);
            spLoad  <= 1'b0;
            mathErr <= 1'b0;
            bv      <= 1'b0;
            take(DBASE + 24'({el - LVL_SOFT_MIN, 1'b0}), el >= LVL_HARD_MIN, el);
        end
        @(posedge ref_clk);
        live   <= 85'({$random(seed), $random(seed), $random(seed)});
        shPush <= 1'b1;
        @(posedge ref_clk);
        shPush <= 1'b0;
        shPop  <= 1'b1;
        @(posedge ref_clk);
        shPop  <= 1'b0;
        #1 check(shc == live, 1'b1);
        check(spv, 1'b1);
        // Address error while a stack error is pending is a lower hard trap: conflict
        @(posedge ref_clk);
        spValue <= 16'h1002;
        spLoad  <= 1'b1;
        @(posedge ref_clk);
        spLoad  <= 1'b0;
        bv      <= 1'b1;
        @(posedge ref_clk);
        bv      <= 1'b0;
        #1 check(cr, 1'b1);
        rd(REG_RESET_CTRL, v);
        check(v, 16'h8000);
        check(haltExec, 1'b0);
        rd(REG_STACK_LIMIT, v);
        check(v, STACK_LIMIT_RST);
        final_report();
    end
    task automatic final_report();
        $display("Mismatches %0d, checks %0d", failures, check_count);
        if (failures == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report
endmodule : tb
`default_nettype wire
